// [design/irq_ctrl_pkg.sv]
// Purpose: shared constants for the instruction-cycle interrupt controller
// Assumes: 32-bit AXI4-Lite register access, 8-bit registers in the low byte
// Notes: shadow context sits in the bank 31 window of the register map
package irq_ctrl_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int CTX_BYTES = 9;
  localparam int ENTRY_CYCLES = 2;

  // register byte offsets
  localparam logic [11:0] OFS_INT_CONTROL = 12'h000;
  localparam logic [11:0] OFS_ENABLE0 = 12'h004;
  localparam logic [11:0] OFS_ENABLE1 = 12'h008;
  localparam logic [11:0] OFS_ENABLE2 = 12'h00c;
  localparam logic [11:0] OFS_FLAG_STATUS = 12'h010;
  // bank 31 of a 128-byte banked space, one word per shadow byte
  localparam logic [4:0] SHADOW_BANK = 5'h1f;

  // interrupt_control fields
  localparam int GLOBAL_EN_BIT = 7;
  localparam int PERIPH_EN_BIT = 6;
  localparam int EDGE_BIT = 0;
  localparam logic [7:0] INT_CONTROL_RESET = 8'h01;
  localparam logic [7:0] INT_CONTROL_MASK = 8'hc1;

  // periph_irq_enable_0..2 implemented bits, all reset to zero
  localparam logic [7:0] ENABLE0_MASK = 8'h31;
  localparam logic [7:0] ENABLE1_MASK = 8'hc3;
  localparam logic [7:0] ENABLE2_MASK = 8'h43;
  localparam logic [7:0] PIE_RESET = 8'h00;
  localparam int EXT_PIN_BIT = 0;

  // flag/status fields
  localparam int STAT_FLAG_BIT = 0;
  localparam int STAT_PEND_BIT = 1;
  localparam int STAT_BUSY_BIT = 2;
  localparam int STAT_WAKE_BIT = 3;

  // context byte order: working, status, bank select, four pointer bytes, pc high, spare
  localparam int CTX_STATUS = 1;
  // timeout and powerdown status bits are never saved on entry; software shadow writes still store them
  localparam logic [7:0] STATUS_SAVE_MASK = 8'he7;

  localparam logic [15:0] VECTOR_ADDR = 16'h0004;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ENTRY = 3'b010,
    ST_WAKE = 3'b100
  } seq_state_t;
endpackage

// [design/mcu_irq_ctrl.sv]
// Purpose: interrupt gating, latency sequencing, sleep wake and context shadowing
// Assumes: core strobes are on ref_clk; extPin is asynchronous
// Notes: one instruction cycle is four Q phases of PHASE_DIV clocks each
//
// The placing of the registers and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps

// Contract
// - synchronous event reaches vector three or four instruction cycles later
// - asynchronous event reaches vector three to five instruction cycles later
// - latency independent of the interrupted instruction's length
// - pending interrupts are sampled once per instruction cycle at Q1
// - external pin flag may set at any phase, including Q4 to Q1
// - wake only from clockless sources enabled before sleep was entered
// - after wake, vector if global enable set, else continue
// - instruction after sleep always executes before the vector
// - external pin edge interrupt enabled by enable-0 bit 0
// - edge select resets to one; one rising, zero falling
// - selected edge sets pin flag; vector when global and pin enables set
// - entry pushes return address and copies context into shadows
// - return reloads context from shadows, software shadow writes win
// - shadows mapped in bank 31, readable and writable
// - global enable bit 7 resets low and gates every interrupt
// - enable registers one and two also need peripheral enable bit 6
// - flags set regardless of any enable
// - enable-0 bits five, four, zero reset low
// - enable-1 bits seven, six, one, zero reset low
// - enable-2 bits six, one, zero reset low
// - unimplemented bits read zero
// - entry flushes prefetch, clears global enable, pushes, loads 0004h
// - return pops address, restores context, sets global enable
// - every reset leaves interrupts disabled
module mcu_irq_ctrl
  import irq_ctrl_pkg::*;
#(
  parameter int PHASE_DIV = 1,
  parameter logic [7:0] WAKE_MASK0 = 8'h31,
  parameter logic [7:0] WAKE_MASK1 = 8'hc3,
  parameter logic [7:0] WAKE_MASK2 = 8'h43
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic extPin,
  input wire logic [7:0] periphFlags0,
  input wire logic [7:0] periphFlags1,
  input wire logic [7:0] periphFlags2,
  input wire logic coreSleep,
  input wire logic returnFromIsr,
  input wire logic [8*CTX_BYTES-1:0] ctxLive,
  output logic q1Strobe,
  output logic irqEntry,
  output logic vectorJump,
  output logic [15:0] vectorAddr,
  output logic wakeReq,
  output logic ctxRestoreValid,
  output logic [8*CTX_BYTES-1:0] ctxRestore
);

  function automatic logic [7:0] orReduce3(input logic [7:0] a, input logic [7:0] b,
                                           input logic [7:0] c);
    orReduce3 = a | b | c;
  endfunction

  function automatic logic isShadow(input logic [ADDR_W-1:0] a);
    isShadow = (a[11:7] == SHADOW_BANK) && (a[6:2] < 5'(CTX_BYTES));
  endfunction

  // phase divider
  logic [15:0] divCnt;
  logic [1:0] qPhase;
  wire phaseTick = (divCnt == 16'(PHASE_DIV - 1));
  wire q1Tick = phaseTick && (qPhase == 2'h3);

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      divCnt <= 16'h0000;
      qPhase <= 2'h0;
    end else begin
      divCnt <= phaseTick ? 16'h0000 : divCnt + 16'h0001;
      if (phaseTick) begin
        qPhase <= qPhase + 2'h1;
      end
    end
  end

  // registers
  logic globalEn;
  logic periphEn;
  logic edgeSel;
  logic [7:0] enable0;
  logic [7:0] enable1;
  logic [7:0] enable2;
  logic [7:0] sleepEnable0;
  logic [7:0] sleepEnable1;
  logic [7:0] sleepEnable2;
  logic extFlag;
  logic [7:0] shadow [CTX_BYTES];
  seq_state_t state;
  logic [1:0] entryCnt;
  logic sleepPrev;

  // external pin synchroniser and edge detect
  logic extSync1;
  logic extSync2;
  logic extPrev;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      extSync1 <= 1'b0;
      extSync2 <= 1'b0;
      extPrev <= 1'b0;
    end else begin
      extSync1 <= extPin;
      extSync2 <= extSync1;
      extPrev <= extSync2;
    end
  end
  wire extEdge = edgeSel ? (extSync2 && !extPrev) : (!extSync2 && extPrev);

  // AXI write channel
  logic [ADDR_W-1:0] awAddrQ;
  logic [7:0] wDataQ;
  logic wStrbQ;
  wire awFire = s_axi_awvalid && s_axi_awready;
  wire wFire = s_axi_wvalid && s_axi_wready;
  wire doWrite = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  wire wrLane = doWrite && wStrbQ;
  wire wrCtl = wrLane && (awAddrQ == OFS_INT_CONTROL);
  wire wrEnable0 = wrLane && (awAddrQ == OFS_ENABLE0);
  wire wrEnable1 = wrLane && (awAddrQ == OFS_ENABLE1);
  wire wrEnable2 = wrLane && (awAddrQ == OFS_ENABLE2);
  wire wrFlag = wrLane && (awAddrQ == OFS_FLAG_STATUS);
  wire wrShadow = wrLane && isShadow(awAddrQ);
  wire [4:0] wrShadowIdx = awAddrQ[6:2];
  wire wrMapped = (awAddrQ == OFS_INT_CONTROL) || (awAddrQ == OFS_ENABLE0) ||
                  (awAddrQ == OFS_ENABLE1) || (awAddrQ == OFS_ENABLE2) ||
                  (awAddrQ == OFS_FLAG_STATUS) || isShadow(awAddrQ);

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      awAddrQ <= '0;
      wDataQ <= 8'h00;
      wStrbQ <= 1'b0;
    end else begin
      if (awFire) begin
        awAddrQ <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (wFire) begin
        wDataQ <= s_axi_wdata[7:0];
        wStrbQ <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (doWrite) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrMapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // interrupt gating
  // flags come straight from sources, unaffected by enables
  wire [7:0] flags0 = {periphFlags0[7:1], extFlag} & ENABLE0_MASK;
  wire [7:0] flags1 = periphFlags1 & ENABLE1_MASK;
  wire [7:0] flags2 = periphFlags2 & ENABLE2_MASK;
  // peripheral enable needed only for registers one and two
  wire periphPend = periphEn && (|((enable1 & flags1) | (enable2 & flags2)));
  // pin source gated by its own enable with other enable-0 sources
  wire pend = (|(enable0 & flags0)) || periphPend;
  // enables latched at sleep entry, wake-capable sources only
  wire wakeAny = |orReduce3(sleepEnable0 & flags0 & WAKE_MASK0,
                            sleepEnable1 & flags1 & WAKE_MASK1,
                            sleepEnable2 & flags2 & WAKE_MASK2);
  wire sleepEnter = coreSleep && !sleepPrev;
  wire sleepExit = !coreSleep && sleepPrev;
  // sampled only at Q1; global enable gates all
  wire takeIrq = q1Tick && (state == ST_IDLE) && globalEn && pend && !coreSleep && !sleepExit;
  wire entryDone = q1Tick && (state == ST_ENTRY) && (entryCnt == 2'(ENTRY_CYCLES - 1));

  // control registers
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      globalEn <= INT_CONTROL_RESET[GLOBAL_EN_BIT];
      periphEn <= INT_CONTROL_RESET[PERIPH_EN_BIT];
      edgeSel <= INT_CONTROL_RESET[EDGE_BIT];
      enable0 <= PIE_RESET;
      enable1 <= PIE_RESET;
      enable2 <= PIE_RESET;
    end else begin
      // hardware clear on entry beats a software write
      if (takeIrq) begin
        globalEn <= 1'b0;
      end else if (returnFromIsr) begin
        globalEn <= 1'b1;
      end else if (wrCtl) begin
        globalEn <= wDataQ[GLOBAL_EN_BIT];
      end
      if (wrCtl) begin
        periphEn <= wDataQ[PERIPH_EN_BIT];
        edgeSel <= wDataQ[EDGE_BIT];
      end
      if (wrEnable0) begin
        enable0 <= wDataQ & ENABLE0_MASK;
      end
      if (wrEnable1) begin
        enable1 <= wDataQ & ENABLE1_MASK;
      end
      if (wrEnable2) begin
        enable2 <= wDataQ & ENABLE2_MASK;
      end
    end
  end

  // pin flag, enables snapshot at sleep entry
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      extFlag <= 1'b0;
      sleepPrev <= 1'b0;
      sleepEnable0 <= PIE_RESET;
      sleepEnable1 <= PIE_RESET;
      sleepEnable2 <= PIE_RESET;
    end else begin
      sleepPrev <= coreSleep;
      // edge sets the flag in any phase; set wins over clear
      if (extEdge) begin
        extFlag <= 1'b1;
      end else if (wrFlag && !wDataQ[STAT_FLAG_BIT]) begin
        extFlag <= 1'b0;
      end
      if (sleepEnter) begin
        sleepEnable0 <= enable0;
        sleepEnable1 <= enable1;
        sleepEnable2 <= enable2;
      end
    end
  end

  // entry sequencer
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state <= ST_IDLE;
      entryCnt <= 2'h0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          // one instruction cycle runs after wake before any take
          if (sleepExit) begin
            state <= ST_WAKE;
          end else if (takeIrq) begin
            state <= ST_ENTRY;
            entryCnt <= 2'h0;
          end
        end
        ST_WAKE: begin
          // back to idle; vectors next Q1 only if global enable set
          if (q1Tick) begin
            state <= ST_IDLE;
          end
        end
        ST_ENTRY: begin
          // fixed count of Q1s, independent of the instruction
          if (entryDone) begin
            state <= ST_IDLE;
          end else if (q1Tick) begin
            entryCnt <= entryCnt + 2'h1;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // shadow context
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < CTX_BYTES; i++) begin
        shadow[i] <= 8'h00;
      end
    end else begin
      for (int i = 0; i < CTX_BYTES; i++) begin
        if (takeIrq) begin
          shadow[i] <= (i == CTX_STATUS) ? (ctxLive[8*i +: 8] & STATUS_SAVE_MASK)
                                         : ctxLive[8*i +: 8];
        end else if (wrShadow && (wrShadowIdx == 5'(i))) begin
          shadow[i] <= wDataQ;
        end
      end
    end
  end

  // core-facing outputs
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      q1Strobe <= 1'b0;
      irqEntry <= 1'b0;
      vectorJump <= 1'b0;
      vectorAddr <= VECTOR_ADDR;
      wakeReq <= 1'b0;
      ctxRestoreValid <= 1'b0;
      ctxRestore <= '0;
    end else begin
      q1Strobe <= q1Tick;
      // flush, push and save in one entry pulse
      irqEntry <= takeIrq;
      vectorJump <= entryDone;
      wakeReq <= coreSleep && wakeAny;
      // restore carries shadow contents, live edits are dropped
      ctxRestoreValid <= returnFromIsr;
      for (int i = 0; i < CTX_BYTES; i++) begin
        ctxRestore[8*i +: 8] <= shadow[i];
      end
    end
  end

  // AXI read channel
  wire [4:0] rdShadowIdx = s_axi_araddr[6:2];
  wire [7:0] statusByte = {4'h0, wakeAny, (state == ST_ENTRY), pend, extFlag};
  wire [7:0] ctlByte = {globalEn, periphEn, 5'h00, edgeSel} & INT_CONTROL_MASK;
  wire rdMapped = (s_axi_araddr == OFS_INT_CONTROL) || (s_axi_araddr == OFS_ENABLE0) ||
                  (s_axi_araddr == OFS_ENABLE1) || (s_axi_araddr == OFS_ENABLE2) ||
                  (s_axi_araddr == OFS_FLAG_STATUS) || isShadow(s_axi_araddr);
  wire [7:0] rdByte = (s_axi_araddr == OFS_INT_CONTROL) ? ctlByte :
                      (s_axi_araddr == OFS_ENABLE0) ? enable0 :
                      (s_axi_araddr == OFS_ENABLE1) ? enable1 :
                      (s_axi_araddr == OFS_ENABLE2) ? enable2 :
                      (s_axi_araddr == OFS_FLAG_STATUS) ? statusByte :
                      isShadow(s_axi_araddr) ? shadow[rdShadowIdx[3:0]] : 8'h00;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h000000, rdByte};
        s_axi_rresp <= rdMapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule

// [tb/mcu_irq_ctrl_chk.sv]
// Purpose: concurrent checks on the interrupt controller ports
// Assumes: one clock domain, asynchronous active-low reset
// Notes: q1 period and jump lag scale with PHASE_DIV; entry and post-sleep windows are fixed at 8 and 4 cycles
`timescale 1ns/1ps
module mcu_irq_ctrl_chk
  import irq_ctrl_pkg::*;
#(
  parameter int PHASE_DIV = 1
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic s_axi_rvalid,
  input wire logic [DATA_W-1:0] s_axi_rdata,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic coreSleep,
  input wire logic returnFromIsr,
  input wire logic q1Strobe,
  input wire logic irqEntry,
  input wire logic vectorJump,
  input wire logic [15:0] vectorAddr,
  input wire logic wakeReq,
  input wire logic ctxRestoreValid
);
  localparam int Q1_LAST = 4 * PHASE_DIV - 1;
  localparam int JUMP_LAG = 8 * PHASE_DIV;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  vec_addr_a: assert property (vectorAddr == VECTOR_ADDR)
    else $error("vector address wrong");
  q1_period_a: assert property (q1Strobe |=> !q1Strobe ##[Q1_LAST:Q1_LAST] q1Strobe)
    else $error("q1 strobe period wrong");
  entry_at_q1_a: assert property (irqEntry |-> q1Strobe)
    else $error("entry not on q1");
  entry_jump_a: assert property (irqEntry |-> ##[JUMP_LAG:JUMP_LAG] vectorJump)
    else $error("vector jump lag wrong");
  single_entry_a: assert property (irqEntry |=> !irqEntry [*8])
    else $error("entry repeated");
  sleep_take_a: assert property (irqEntry |-> !$past(coreSleep))
    else $error("entry while asleep");
  after_sleep_a: assert property ($fell(coreSleep) |-> !irqEntry [*4])
    else $error("entry before post-sleep instruction");
  wake_asleep_a: assert property (wakeReq |-> $past(coreSleep))
    else $error("wake while awake");
  restore_pulse_a: assert property (returnFromIsr |=> ctxRestoreValid)
    else $error("no restore after return");
  rdata_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  cover property (irqEntry);
  cover property (wakeReq);
  cover property (ctxRestoreValid);
  cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule

bind mcu_irq_ctrl mcu_irq_ctrl_chk #(.PHASE_DIV(PHASE_DIV)) chk (.ref_clk, .nrst,
  .s_axi_rvalid, .s_axi_rdata, .s_axi_bresp, .s_axi_bvalid, .coreSleep, .returnFromIsr,
  .q1Strobe, .irqEntry, .vectorJump, .vectorAddr, .wakeReq, .ctxRestoreValid);

// [tb/core_model.sv]
// Purpose: behavioural core sequencer facing the interrupt controller
// Assumes: a service routine lasts ISR_LEN cycles and alters live context
// Notes: live context changes only at vector jump and restore
`timescale 1ns/1ps
module core_model
  import irq_ctrl_pkg::*;
#(
  parameter int ISR_LEN = 60,
  parameter logic [8*CTX_BYTES-1:0] CTX_INIT = 72'h0123456789abcdef5a
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic sleepReq,
  input wire logic vectorJump,
  input wire logic ctxRestoreValid,
  input wire logic [8*CTX_BYTES-1:0] ctxRestore,
  output logic coreSleep,
  output logic returnFromIsr,
  output logic [8*CTX_BYTES-1:0] ctxLive
);
  int left;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      coreSleep <= 1'b0;
      returnFromIsr <= 1'b0;
      ctxLive <= CTX_INIT;
      left <= 0;
    end else begin
      coreSleep <= sleepReq;
      returnFromIsr <= (left == 1);
      if (left > 0) left <= left - 1;
      // routine scribbles over live context, which the return must undo
      if (vectorJump) begin
        ctxLive <= ~ctxLive;
        left <= ISR_LEN;
      end
      if (ctxRestoreValid) ctxLive <= ctxRestore;
    end
  end
endmodule

// [tb/tb_top.sv]
// Purpose: self-checking bench for the interrupt controller
// Assumes: PHASE_DIV 1, core model returns after a fixed service time
// Notes: seed 33; expectations come from package constants, exp_take and sampled live context
`timescale 1ns/1ps
module tb_top
  import irq_ctrl_pkg::*;
;
  logic ref_clk = 0, nrst = 0, extPin = 0, sleepReq = 0;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, coreSleep, returnFromIsr, q1Strobe, irqEntry, vectorJump;
  logic wakeReq, ctxRestoreValid;
  logic [7:0] periphFlags0 = 0, periphFlags1 = 0, periphFlags2 = 0;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [15:0] vectorAddr;
  logic [71:0] ctxLive, ctxRestore, liveAt;
  int failures = 0, testsRun = 0, entries = 0, cyc = 0, jumpAt = 0;

  always #2.5 ref_clk = ~ref_clk;

  mcu_irq_ctrl dut (.ref_clk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .extPin, .periphFlags0, .periphFlags1,
    .periphFlags2, .coreSleep, .returnFromIsr, .ctxLive, .q1Strobe, .irqEntry,
    .vectorJump, .vectorAddr, .wakeReq, .ctxRestoreValid, .ctxRestore);
  core_model core (.ref_clk, .nrst, .sleepReq, .vectorJump, .ctxRestoreValid,
    .ctxRestore, .coreSleep, .returnFromIsr, .ctxLive);

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (irqEntry === 1'b1) begin
      entries <= entries + 1;
      liveAt <= ctxLive;
    end
    if (vectorJump === 1'b1) jumpAt <= cyc;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    testsRun++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", testsRun, failures);
    if (failures == 0 && testsRun > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r = 2'b00);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    check(s_axi_bresp, r);
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r = 2'b00);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    check(s_axi_rdata, {24'h0, d});
    check(s_axi_rresp, r);
  endtask

  task automatic wait_restore();
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (ctxRestoreValid !== 1'b1 && n < 200);
    check(n < 200, 1);
  endtask

  function automatic logic exp_take(input logic [7:0] e0, x0, e1, x1, e2, x2,
                                    input logic g, pe);
    return g & ((|(e0 & x0 & 8'h30)) | (pe & (|(e1 & x1 & ENABLE1_MASK | e2 & x2 & ENABLE2_MASK))));
  endfunction

  initial begin
    logic [11:0] ra [4];
    logic [7:0] rm [4], rr [4], v, p0, p1, p2, f0, f1, f2;
    logic g, pe;
    int c0, e0;
    ra = '{OFS_INT_CONTROL, OFS_ENABLE0, OFS_ENABLE1, OFS_ENABLE2};
    rm = '{INT_CONTROL_MASK, ENABLE0_MASK, ENABLE1_MASK, ENABLE2_MASK};
    rr = '{INT_CONTROL_RESET, PIE_RESET, PIE_RESET, PIE_RESET};
    v = $urandom(33);
    repeat (3) @(posedge ref_clk);
    nrst <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      rd(ra[i], rr[i]);
      v = $urandom;
      wr(ra[i], v);
      rd(ra[i], v & rm[i]);
      wr(ra[i], rr[i]);
    end
    wr(12'h020, 8'hff, RESP_SLVERR);
    rd(12'h020, 8'h00, RESP_SLVERR);
    for (int i = 0; i < CTX_BYTES; i++) begin
      v = $urandom & ((i == CTX_STATUS) ? STATUS_SAVE_MASK : 8'hff);
      wr(12'hf80 + 12'(4 * i), v);
      rd(12'hf80 + 12'(4 * i), v);
    end
    $display("test registers done");
    extPin <= 1'b1;
    repeat (8) @(posedge ref_clk);
    rd(OFS_FLAG_STATUS, 8'h01);
    wr(OFS_FLAG_STATUS, 8'h00);
    rd(OFS_FLAG_STATUS, 8'h00);
    wr(OFS_INT_CONTROL, 8'h00);
    extPin <= 1'b0;
    repeat (8) @(posedge ref_clk);
    rd(OFS_FLAG_STATUS, 8'h01);
    wr(OFS_FLAG_STATUS, 8'h00);
    wr(OFS_ENABLE0, 8'h01);
    wr(OFS_INT_CONTROL, 8'h81);
    e0 = entries;
    c0 = cyc;
    extPin <= 1'b1;
    // worst case five instruction cycles
    repeat (24) @(posedge ref_clk);
    check((jumpAt - c0) inside {[12:20]}, 1);
    check(entries - e0, 1);
    rd(OFS_INT_CONTROL, 8'h01);
    wr(OFS_FLAG_STATUS, 8'h00);
    rd(12'hf84, liveAt[15:8] & STATUS_SAVE_MASK);
    wr(12'hf80, 8'ha5);
    wait_restore();
    check(ctxRestore[7:0], 8'ha5);
    check(ctxRestore[23:16], liveAt[23:16]);
    rd(OFS_INT_CONTROL, 8'h81);
    $display("test pin vector done");
    for (int k = 0; k < 8; k++) begin
      {p0, p1, p2, f0} = $urandom;
      {f1, f2, g, pe} = $urandom;
      wr(OFS_ENABLE0, p0 & 8'h30);
      wr(OFS_ENABLE1, p1);
      wr(OFS_ENABLE2, p2);
      wr(OFS_INT_CONTROL, {g, pe, 6'h01});
      e0 = entries;
      periphFlags0 <= f0;
      periphFlags1 <= f1;
      periphFlags2 <= f2;
      repeat (16) @(posedge ref_clk);
      check(entries - e0, exp_take(p0, f0, p1, f1, p2, f2, g, pe));
      periphFlags0 <= 8'h00;
      periphFlags1 <= 8'h00;
      periphFlags2 <= 8'h00;
      if (entries != e0) wait_restore();
    end
    $display("test gating done");
    wr(OFS_INT_CONTROL, 8'h01);
    wr(OFS_ENABLE0, 8'h00);
    sleepReq <= 1'b1;
    repeat (4) @(posedge ref_clk);
    wr(OFS_ENABLE0, 8'h10);
    periphFlags0 <= 8'h10;
    repeat (4) @(posedge ref_clk);
    check(wakeReq, 0);
    sleepReq <= 1'b0;
    periphFlags0 <= 8'h00;
    repeat (4) @(posedge ref_clk);
    sleepReq <= 1'b1;
    repeat (4) @(posedge ref_clk);
    periphFlags0 <= 8'h10;
    repeat (4) @(posedge ref_clk);
    check(wakeReq, 1);
    e0 = entries;
    sleepReq <= 1'b0;
    repeat (16) @(posedge ref_clk);
    check(entries - e0, 0);
    // asleep with global enable set: wake, one instruction, then vector
    sleepReq <= 1'b1;
    repeat (4) @(posedge ref_clk);
    wr(OFS_INT_CONTROL, 8'h81);
    check(entries - e0, 0);
    sleepReq <= 1'b0;
    repeat (24) @(posedge ref_clk);
    check(entries - e0, 1);
    periphFlags0 <= 8'h00;
    wait_restore();
    $display("test sleep done");
    give_verdict();
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    give_verdict();
  end
endmodule
